// file: src/mbam_top.sv
// address extension and region decode between core and module bus
//
// Summary of operation
// - core drives 20 address and 16 data bits onto the 24-bit bus
// - bus address bits 23..20 copy bit 19 whenever the core drives
// - register block top nibble is map select followed by three ones
// - core accesses never land between 080000 and F7FFFF
// - map select zero puts registers at 7FF000, unreachable until reset
// - static RAM follows the RAM base address register
// - unimplemented regions go to the external bus
// - reset and exception vectors always come from bank 0
// - program counter, stack and Z index take any extended address
// - register block is 4 kbyte at 7FF000 or FFF000
// - map select resets to one and takes only one write
`timescale 1ns/100ps
module mbam_top (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // core side
    input  wire logic                   core_valid,
    input  wire logic [19:0]            core_addr,
    input  wire logic                   core_vector_fetch,
    input  wire logic [2:0]             core_space_code,
    input  wire logic                   core_write,
    input  wire logic [15:0]            core_wdata,
    // configuration writes
    input  wire logic                   map_select_wr,
    input  wire logic                   map_select_wdata,
    input  wire logic                   ram_base_wr,
    input  wire logic [12:0]            ram_base_wdata,
    // module bus side
    output logic                        bus_valid,
    output logic [23:0]                 bus_addr,
    output logic [2:0]                  space_code,
    output logic                        bus_write,
    output logic [15:0]                 bus_wdata,
    output logic                        reg_sel,
    output logic                        ram_sel,
    output logic                        ext_sel,
    // status
    output logic                        map_select_bit,
    output logic                        map_select_locked
);
    // placement state
    logic                   map_sel_q;
    logic                   map_lock_q;
    logic [12:0]            ram_base_q;
    // next values of the placement state
    wire logic              map_wr_ok;
    wire logic              map_sel_d;
    wire logic              map_lock_d;
    wire logic [12:0]       ram_base_d;
    // address path
    wire logic [19:0]       eff_addr;
    wire logic [3:0]        top_bits;
    wire logic [23:0]       ext_addr;
    // decode result
    mbam_pkg::mbam_target_t target;
    wire logic              tgt_reg;
    wire logic              tgt_ram;
    wire logic              tgt_ext;

    // vectors are fixed in bank 0; bank bits forced regardless of map
    assign eff_addr = core_vector_fetch ?
                      {mbam_pkg::VEC_BANK, core_addr[15:0]} :
                      core_addr;

    // per-bit copies of bit 19 keep the core out of the middle hole
    genvar gi;
    generate
        for (gi = 0; gi < mbam_pkg::EXT_HI; gi = gi + 1)
        begin : g_ext_bit
            assign top_bits[gi] = eff_addr[mbam_pkg::ADDR19_POS];
        end
    endgenerate

    // full 20-bit address passes through, so PC/SP/Z reach any bank
    assign ext_addr = {top_bits, eff_addr};

    mbam_decode u_decode (
        .bus_addr       (ext_addr),
        .valid          (core_valid),
        .map_select_bit (map_sel_q),
        .ram_base       (ram_base_q),
        .target         (target)
    );

    // one-hot selects taken straight from the target code
    assign tgt_reg = (target == mbam_pkg::MBAM_TGT_REG);
    assign tgt_ram = (target == mbam_pkg::MBAM_TGT_RAM);
    assign tgt_ext = (target == mbam_pkg::MBAM_TGT_EXT);

    // map select: first write wins, later ones dropped until reset
    assign map_wr_ok  = map_select_wr && !map_lock_q;
    assign map_sel_d  = map_wr_ok ? map_select_wdata : map_sel_q;
    assign map_lock_d = map_lock_q || map_wr_ok;
    // the ram base may be moved at any time
    assign ram_base_d = ram_base_wr ? ram_base_wdata : ram_base_q;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            map_sel_q <= mbam_pkg::MAP_SEL_RST;
        end
        else
        begin
            map_sel_q <= map_sel_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            map_lock_q <= 1'h0;
        end
        else
        begin
            map_lock_q <= map_lock_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ram_base_q <= mbam_pkg::RAM_BASE_RST;
        end
        else
        begin
            ram_base_q <= ram_base_d;
        end
    end

    // registered outputs; one cycle of latency traded for clean timing
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bus_valid <= 1'h0;
        end
        else
        begin
            bus_valid <= core_valid;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bus_addr <= 24'h000000;
        end
        else
        begin
            bus_addr <= ext_addr;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            space_code <= 3'h0;
        end
        else
        begin
            space_code <= core_space_code;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bus_write <= 1'h0;
        end
        else
        begin
            bus_write <= core_write;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bus_wdata <= 16'h0000;
        end
        else
        begin
            bus_wdata <= core_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            reg_sel <= 1'h0;
        end
        else
        begin
            reg_sel <= tgt_reg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ram_sel <= 1'h0;
        end
        else
        begin
            ram_sel <= tgt_ram;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ext_sel <= 1'h0;
        end
        else
        begin
            ext_sel <= tgt_ext;
        end
    end

    // status lags the internal state by one cycle, like the selects
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            map_select_bit <= mbam_pkg::MAP_SEL_RST;
        end
        else
        begin
            map_select_bit <= map_sel_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            map_select_locked <= 1'h0;
        end
        else
        begin
            map_select_locked <= map_lock_q;
        end
    end
endmodule : mbam_top

// file: shared/mbam_pkg.sv
// constants for the module bus address map
package mbam_pkg;
    localparam int CORE_AW      = 20;
    localparam int BUS_AW       = 24;
    localparam int DATA_W       = 16;
    localparam int EXT_HI       = 4;
    localparam int ADDR19_POS   = 19;
    localparam int BASE_W       = 12;
    localparam int RAM_BASE_W   = 13;
    localparam int RAM_SIZE_W   = 11;
    localparam logic [2:0]  LOW_ONES     = 3'h7;
    localparam logic [7:0]  REG_BASE_LO  = 8'hFF;
    localparam logic [23:0] HOLE_LO      = 24'h080000;
    localparam logic [23:0] HOLE_HI      = 24'hF7FFFF;
    localparam logic        MAP_SEL_RST  = 1'h1;
    localparam logic [3:0]  VEC_BANK     = 4'h0;
    localparam logic [RAM_BASE_W-1:0] RAM_BASE_RST = 13'h0000;
    typedef enum logic [1:0] {
        MBAM_TGT_NONE = 2'b00,
        MBAM_TGT_REG  = 2'b01,
        MBAM_TGT_RAM  = 2'b10,
        MBAM_TGT_EXT  = 2'b11
    } mbam_target_t;
endpackage : mbam_pkg

// file: src/mbam_decode.sv
// combinational target decode of one 24-bit bus address
`timescale 1ns/100ps
module mbam_decode (
    // address
    input  wire logic [23:0]             bus_addr,
    input  wire logic                    valid,
    // placement
    input  wire logic                    map_select_bit,
    input  wire logic [12:0]             ram_base,
    // result
    output mbam_pkg::mbam_target_t       target
);
    wire logic [11:0] reg_base;
    wire logic        reg_hit;
    wire logic        ram_hit;

    assign reg_base = {map_select_bit, mbam_pkg::LOW_ONES,
                       mbam_pkg::REG_BASE_LO};
    assign reg_hit  = (bus_addr[23:12] == reg_base);
    // ram window is 2 kbyte, placed on a 2 kbyte boundary
    assign ram_hit  = (bus_addr[23:11] == ram_base);
    assign target   = !valid  ? mbam_pkg::MBAM_TGT_NONE :
                      reg_hit ? mbam_pkg::MBAM_TGT_REG  :
                      ram_hit ? mbam_pkg::MBAM_TGT_RAM  :
                                mbam_pkg::MBAM_TGT_EXT;
endmodule : mbam_decode

// file: verification/mbam_asserts.sv
// assertions on the address map ports
`timescale 1ns/100ps
module mbam_asserts (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // core side
    input  wire logic        core_valid,
    input  wire logic        core_vector_fetch,
    input  wire logic [19:0] core_addr,
    // configuration writes
    input  wire logic        map_select_wr,
    input  wire logic        map_select_wdata,
    // module bus side
    input  wire logic        bus_valid,
    input  wire logic [23:0] bus_addr,
    input  wire logic        reg_sel,
    input  wire logic        ram_sel,
    input  wire logic        ext_sel,
    // status
    input  wire logic        map_select_bit,
    input  wire logic        map_select_locked
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_clear;
        map_select_wr && !map_select_wdata && !map_select_locked
            && !$past(map_select_wr);
    endsequence
    chk_top_copy: assert property (bus_valid |->
        bus_addr[23:20] == {4{bus_addr[19]}}) else $error("top bits");
    chk_low_pass: assert property (core_valid && !core_vector_fetch |=>
        bus_valid && bus_addr[19:0] == $past(core_addr)) else $error("addr");
    chk_hole_skip: assert property (bus_valid |->
        !(bus_addr inside {[mbam_pkg::HOLE_LO:mbam_pkg::HOLE_HI]}))
        else $error("hole");
    chk_vec_bank: assert property (core_valid && core_vector_fetch |=>
        bus_addr[23:16] == 8'h00) else $error("vector bank");
    chk_reg_match: assert property (reg_sel == (bus_valid &&
        bus_addr[23:12] == {map_select_bit, 11'h7FF})) else $error("reg");
    chk_ext_rest: assert property (bus_valid && !reg_sel && !ram_sel |->
        ext_sel) else $error("ext");
    chk_idle_quiet: assert property (!bus_valid |->
        !reg_sel && !ram_sel && !ext_sel) else $error("idle select");
    chk_one_write: assert property ($past(map_select_locked, 2) |->
        $stable(map_select_bit)) else $error("relock");
    chk_clear_lands: assert property (s_clear |-> ##[1:2]
        !map_select_bit && map_select_locked) else $error("clear");
endmodule : mbam_asserts
bind mbam_top mbam_asserts chk (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .core_valid        (core_valid),
    .core_vector_fetch (core_vector_fetch),
    .core_addr         (core_addr),
    .map_select_wr     (map_select_wr),
    .map_select_wdata  (map_select_wdata),
    .bus_valid         (bus_valid),
    .bus_addr          (bus_addr),
    .reg_sel           (reg_sel),
    .ram_sel           (ram_sel),
    .ext_sel           (ext_sel),
    .map_select_bit    (map_select_bit),
    .map_select_locked (map_select_locked)
);

// file: verification/mbam_far_model.sv
// far-side responders: which module answers the cycle
`timescale 1ns/100ps
module mbam_far_model #(
    parameter logic [2:0] PROG_CODE = 3'h6
) (
    // selects and space code from the block
    input  wire logic              reg_sel,
    input  wire logic              ram_sel,
    input  wire logic              ext_sel,
    input  wire logic [2:0]        space_code,
    // responder seen by the bench
    output mbam_pkg::mbam_target_t hit,
    output logic                   prog_ext
);
    // outside decode splits program from data on the space code
    assign prog_ext = ext_sel && (space_code == PROG_CODE);
    // priority only matters if the selects ever overlap
    assign hit = reg_sel ? mbam_pkg::MBAM_TGT_REG : ram_sel ?
        mbam_pkg::MBAM_TGT_RAM : ext_sel ? mbam_pkg::MBAM_TGT_EXT :
        mbam_pkg::MBAM_TGT_NONE;
endmodule : mbam_far_model

// file: verification/mbam_top_tb.sv
// self-checking bench for the address map
`timescale 1ns/100ps
module mbam_top_tb;
    logic clk = 1'h0, sys_rst = 1'h1, core_valid = 1'h0, ram_base_wr = 1'h0;
    logic core_vector_fetch = 1'h0, map_select_wr = 1'h0;
    logic map_select_wdata = 1'h0, bus_valid, bus_write, reg_sel, ram_sel;
    logic ext_sel, map_select_bit, map_select_locked;
    logic [19:0] core_addr = 20'h00000;
    logic [12:0] ram_base_wdata = 13'h0000;
    logic [23:0] bus_addr;
    logic [15:0] bus_wdata;
    logic [2:0]  space_code;
    // data, code and direction ride on the address so nothing is tied
    wire  [15:0] core_wdata = core_addr[15:0];
    wire  [2:0]  core_space_code = core_addr[2:0];
    wire         core_write = core_addr[0];
    mbam_pkg::mbam_target_t hit;
    logic prog_ext;
    localparam logic [2:0] PROG_CODE = 3'h6;
    int miscompares = 0;
    int tests_run = 0;
    mbam_top uut (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .core_valid        (core_valid),
        .core_addr         (core_addr),
        .core_vector_fetch (core_vector_fetch),
        .core_space_code   (core_space_code),
        .core_write        (core_write),
        .core_wdata        (core_wdata),
        .map_select_wr     (map_select_wr),
        .map_select_wdata  (map_select_wdata),
        .ram_base_wr       (ram_base_wr),
        .ram_base_wdata    (ram_base_wdata),
        .bus_valid         (bus_valid),
        .bus_addr          (bus_addr),
        .space_code        (space_code),
        .bus_write         (bus_write),
        .bus_wdata         (bus_wdata),
        .reg_sel           (reg_sel),
        .ram_sel           (ram_sel),
        .ext_sel           (ext_sel),
        .map_select_bit    (map_select_bit),
        .map_select_locked (map_select_locked)
    );
    mbam_far_model #(.PROG_CODE(PROG_CODE)) far (
        .reg_sel    (reg_sel),
        .ram_sel    (ram_sel),
        .ext_sel    (ext_sel),
        .space_code (space_code),
        .hit        (hit),
        .prog_ext   (prog_ext)
    );
    always #50 clk = ~clk;
    task automatic cmp(input string what, input logic [23:0] exp, got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask : cmp
    task automatic acc(input logic [19:0] a, input logic v,
        input logic [23:0] ea, input mbam_pkg::mbam_target_t et);
        core_valid <= 1'h1;
        core_addr <= a;
        core_vector_fetch <= v;
        @(posedge clk);
        core_valid <= 1'h0;
        #1;
        cmp("bus_addr", ea, bus_addr);
        cmp("target", {22'h0, et}, {22'h0, hit});
        cmp("bus_wdata", {8'h00, a[15:0]}, {8'h00, bus_wdata});
        cmp("bus_valid", 24'h000001, {23'h0, bus_valid});
        cmp("bus_write", {23'h0, a[0]}, {23'h0, bus_write});
        cmp("space_code", {21'h0, a[2:0]}, {21'h0, space_code});
        cmp("prog_ext", {23'h0, (et == mbam_pkg::MBAM_TGT_EXT) &&
            (a[2:0] == PROG_CODE)}, {23'h0, prog_ext});
        @(posedge clk);
    endtask : acc
    task automatic t_default_map;
        acc(20'h00100, 1'h0, 24'h000100, mbam_pkg::MBAM_TGT_RAM);
        acc(20'hFF000, 1'h0, 24'hFFF000, mbam_pkg::MBAM_TGT_REG);
        acc(20'h7FFFE, 1'h0, 24'h07FFFE, mbam_pkg::MBAM_TGT_EXT);
        acc(20'h80002, 1'h0, 24'hF80002, mbam_pkg::MBAM_TGT_EXT);
        acc(20'hFFFFE, 1'h1, 24'h00FFFE, mbam_pkg::MBAM_TGT_EXT);
    endtask : t_default_map
    task automatic t_ram_move;
        ram_base_wdata <= 13'h0002;
        ram_base_wr <= 1'h1;
        @(posedge clk);
        ram_base_wr <= 1'h0;
        @(posedge clk);
        acc(20'h01000, 1'h0, 24'h001000, mbam_pkg::MBAM_TGT_RAM);
        acc(20'h01800, 1'h0, 24'h001800, mbam_pkg::MBAM_TGT_EXT);
        acc(20'h00100, 1'h0, 24'h000100, mbam_pkg::MBAM_TGT_EXT);
    endtask : t_ram_move
    task automatic t_map_clear;
        map_select_wr <= 1'h1;
        @(posedge clk);
        map_select_wdata <= 1'h1;
        @(posedge clk);
        map_select_wr <= 1'h0;
        repeat (2) @(posedge clk);
        #1;
        cmp("map_bit", 24'h0, {23'h0, map_select_bit});
        cmp("locked", 24'h1, {23'h0, map_select_locked});
        @(posedge clk);
        acc(20'hFF000, 1'h0, 24'hFFF000, mbam_pkg::MBAM_TGT_EXT);
        sys_rst <= 1'h1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        #1;
        cmp("map_bit", 24'h1, {23'h0, map_select_bit});
        cmp("locked", 24'h0, {23'h0, map_select_locked});
        @(posedge clk);
        acc(20'hFF000, 1'h0, 24'hFFF000, mbam_pkg::MBAM_TGT_REG);
    endtask : t_map_clear
    task automatic tally_and_finish;
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        t_default_map;
        t_ram_move;
        t_map_clear;
        tally_and_finish;
    end
    initial
    begin
        #400000;
        miscompares++;
        tally_and_finish;
    end
endmodule : mbam_top_tb
